// ===== rtl/ramp_mode_defs.vh
// Constants shared by the ramp mode and speed threshold logic.
`ifndef RAMP_MODE_DEFS_VH
`define RAMP_MODE_DEFS_VH

// Register port geometry.
`define REG_ADDR_W 7
`define REG_DATA_W 32

// Register offsets.
`define ADDR_HIGH_SPEED_THRESHOLD 7'h15
`define ADDR_MOTION_PROFILE 7'h20
`define ADDR_CURRENT_POSITION 7'h21
`define ADDR_CURRENT_VELOCITY 7'h22

// Field widths.
`define THRESH_W 20
`define PROFILE_W 2
`define POSITION_W 32
`define VELOCITY_W 24
`define FAST_DECAY_W 4

// Reset values.
`define RST_THRESHOLD 20'h00000
`define RST_PROFILE 2'h0
`define RST_POSITION 32'h00000000
`define RST_VELOCITY 24'h000000
`define RST_RDATA 32'h00000000

// Motion profile encodings.
`define PROFILE_POSITIONING 2'h0
`define PROFILE_VELOCITY_POS 2'h1
`define PROFILE_VELOCITY_NEG 2'h2
`define PROFILE_HOLD 2'h3

// Chopper values forced in the high speed range.
`define CHOPPER_TYPE_FORCED 1'b1
`define FAST_DECAY_FORCED 4'h0

// Stall blanking after a threshold crossing, in electrical period ticks.
`define BLANK_CNT_W 2
`define BLANK_TICKS 2'h3
`define BLANK_ZERO 2'h0
`define BLANK_ONE 2'h1

// Velocity limits of the signed readout, and the position step.
`define VELOCITY_MOST_NEG 24'h800000
`define VELOCITY_LEAST_NEG_OK 24'h800001
`define POSITION_ONE 32'h00000001

`endif

// ===== rtl/stall_blank_timer.v
// Stall detection blanking timer started by a threshold crossing.
`timescale 1ns/1ns
`default_nettype none
`include "ramp_mode_defs.vh"

module stall_blank_timer (
  input wire ref_clk,
  input wire rst,
  input wire crossing,
  input wire period_tick,
  output reg blanking
);

  reg [`BLANK_CNT_W-1:0] ticks_left;

  // Counting three tick edges after the crossing gives between two and three
  // whole periods, since the crossing lands anywhere inside a period.
  always @(posedge ref_clk) begin
    if (rst) begin
      ticks_left <= `BLANK_ZERO;
      blanking <= 1'b0;
    end else if (crossing) begin
      ticks_left <= `BLANK_TICKS;
      blanking <= 1'b1;
    end else if (blanking && period_tick) begin
      ticks_left <= ticks_left - `BLANK_ONE;
      if (ticks_left == `BLANK_ONE) begin
        blanking <= 1'b0;
      end
    end
  end

endmodule // stall_blank_timer
`default_nettype wire

// ===== rtl/ramp_mode_and_speed_threshold.v
// Speed threshold, motion profile, position and velocity registers of the motion unit.
//
// Summary of operation
// - 20-bit unsigned high speed step time threshold, resets to zero, read and write.
// - Each threshold crossing either way blanks stall detection for 2 to 3 periods.
// - At or below threshold, load-adaptive current reduction is off, normal current scale.
// - At or below threshold, voltage PWM chopper mode is off.
// - With fast chopper switch, high speed forces chopper type 1, fast decay 0.
// - With fast fullstep, high speed drives fullstep and dynamic-step stall detection.
// - Profile select in bits 1:0, resets to zero; 0 is positioning mode.
// - Profile 1 runs velocity mode to positive speed limit, main acceleration only.
// - Profile 2 runs velocity mode to negative speed limit, main acceleration only.
// - Profile 3 holds present velocity unless a stop event occurs.
// - Signed 32-bit current position, resets to zero, read and write.
// - In positioning mode a position write starts motion toward the target.
// - Signed 24-bit read-only velocity, resets to zero, range plus or minus 2^23-1.
// - Velocity sign follows direction; negative means position decreasing.
// - Load-adaptive control allowed only above threshold, up to and including the speed floor.
`timescale 1ns/1ns
`default_nettype none
`include "ramp_mode_defs.vh"

module ramp_mode_and_speed_threshold (
  input wire ref_clk,
  input wire rst,
  // Register port.
  input wire [`REG_ADDR_W-1:0] reg_addr,
  input wire [`REG_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`REG_DATA_W-1:0] reg_rdata,
  output reg reg_rvalid,
  // Measured step interval and load-adapt floor from the rest of the unit.
  input wire [`THRESH_W-1:0] measured_step_interval,
  input wire [`THRESH_W-1:0] load_adapt_speed_floor,
  // Chopper and feature configuration from the rest of the unit.
  input wire load_adapt_cfg_en,
  input wire voltage_pwm_cfg_en,
  input wire fast_chopper_switch_en,
  input wire fast_fullstep_en,
  input wire chopper_type_cfg,
  input wire [`FAST_DECAY_W-1:0] fast_decay_cfg,
  input wire stall_detect_cfg_en,
  // Ramp generator side.
  input wire electrical_period_tick,
  input wire [`VELOCITY_W-1:0] ramp_velocity,
  input wire ramp_velocity_valid,
  input wire step_pulse,
  input wire stop_event,
  // Chopper and stall controls.
  output reg high_speed,
  output reg load_adapt_en,
  output reg normal_current_scale,
  output reg voltage_pwm_en,
  output reg chopper_type,
  output reg [`FAST_DECAY_W-1:0] fast_decay_duration,
  output reg fullstep_en,
  output reg stall_detect_en,
  output reg dyn_step_stall_sel,
  // Motion profile controls.
  output reg positioning_mode,
  output reg velocity_mode,
  output reg velocity_target_negative,
  output reg main_accel_only,
  output reg hold_velocity,
  output reg motion_start,
  output reg step_dir_down
);

  // Software visible state.
  reg [`THRESH_W-1:0] high_speed_step_time_threshold;
  reg [`PROFILE_W-1:0] motion_profile_select;
  reg [`POSITION_W-1:0] current_position;
  reg [`VELOCITY_W-1:0] current_velocity;

  // Internal state.
  reg high_speed_prev;
  reg high_speed_seen;

  wire blanking;
  wire in_high_speed;
  wire in_load_window;
  wire crossing;
  wire wr_threshold;
  wire wr_profile;
  wire wr_position;
  wire [`VELOCITY_W-1:0] clamped_velocity;
  wire load_adapt_active;
  wire fast_chop_active;
  wire fast_fullstep_active;

  reg [`REG_DATA_W-1:0] next_rdata;

  // Unsigned at-or-below compare of two step intervals.
  function at_or_below;
    input [`THRESH_W-1:0] value;
    input [`THRESH_W-1:0] limit;
    begin
      at_or_below = (value <= limit);
    end
  endfunction

  // Zero extension of a field to a full data word.
  function [`REG_DATA_W-1:0] widen20;
    input [`THRESH_W-1:0] field;
    begin
      widen20 = {{(`REG_DATA_W-`THRESH_W){1'b0}}, field};
    end
  endfunction

  // Zero extension of the profile field to a full data word.
  function [`REG_DATA_W-1:0] widen_profile;
    input [`PROFILE_W-1:0] field;
    begin
      widen_profile = {{(`REG_DATA_W-`PROFILE_W){1'b0}}, field};
    end
  endfunction

  // Zero extension of the velocity field; the sign is not carried upward.
  function [`REG_DATA_W-1:0] widen_velocity;
    input [`VELOCITY_W-1:0] field;
    begin
      widen_velocity = {{(`REG_DATA_W-`VELOCITY_W){1'b0}}, field};
    end
  endfunction

  // Address decode of the write strobes.
  assign wr_threshold = reg_wr && (reg_addr == `ADDR_HIGH_SPEED_THRESHOLD);
  assign wr_profile = reg_wr && (reg_addr == `ADDR_MOTION_PROFILE);
  assign wr_position = reg_wr && (reg_addr == `ADDR_CURRENT_POSITION);

  // Speed range classification.
  // The equal bound counts as high speed, so the load window opens just above it.
  assign in_high_speed = at_or_below(measured_step_interval,
                                     high_speed_step_time_threshold);
  assign in_load_window = !in_high_speed &&
                          at_or_below(measured_step_interval,
                                      load_adapt_speed_floor);

  // Feature qualifiers shared by several registered controls.
  assign load_adapt_active = load_adapt_cfg_en && in_load_window;
  assign fast_chop_active = fast_chopper_switch_en && in_high_speed;
  assign fast_fullstep_active = fast_fullstep_en && in_high_speed;

  // A crossing is only counted once a previous sample exists.
  assign crossing = high_speed_seen && (in_high_speed != high_speed_prev);

  // The most negative code has no positive twin, so it is folded in.
  assign clamped_velocity = (ramp_velocity == `VELOCITY_MOST_NEG) ?
                            `VELOCITY_LEAST_NEG_OK : ramp_velocity;

  stall_blank_timer u_blank (
    .ref_clk(ref_clk),
    .rst(rst),
    .crossing(crossing),
    .period_tick(electrical_period_tick),
    .blanking(blanking)
  );

  // Threshold register.
  always @(posedge ref_clk) begin
    if (rst) begin
      high_speed_step_time_threshold <= `RST_THRESHOLD;
    end else if (wr_threshold) begin
      high_speed_step_time_threshold <= reg_wdata[`THRESH_W-1:0];
    end
  end

  // Motion profile register.
  always @(posedge ref_clk) begin
    if (rst) begin
      motion_profile_select <= `RST_PROFILE;
    end else if (wr_profile) begin
      motion_profile_select <= reg_wdata[`PROFILE_W-1:0];
    end
  end

  // Position counter; a software write takes priority over a step.
  always @(posedge ref_clk) begin
    if (rst) begin
      current_position <= `RST_POSITION;
    end else if (wr_position) begin
      current_position <= reg_wdata;
    end else if (step_pulse) begin
      if (current_velocity[`VELOCITY_W-1]) begin
        current_position <= current_position - `POSITION_ONE;
      end else begin
        current_position <= current_position + `POSITION_ONE;
      end
    end
  end

  // Velocity readout, read only.
  always @(posedge ref_clk) begin
    if (rst) begin
      current_velocity <= `RST_VELOCITY;
    end else if (ramp_velocity_valid) begin
      current_velocity <= clamped_velocity;
    end
  end

  // Direction of steps follows the velocity sign.
  always @(posedge ref_clk) begin
    if (rst) begin
      step_dir_down <= 1'b0;
    end else if (ramp_velocity_valid) begin
      step_dir_down <= clamped_velocity[`VELOCITY_W-1];
    end
  end

  // Crossing tracker.
  always @(posedge ref_clk) begin
    if (rst) begin
      high_speed_prev <= 1'b0;
      high_speed_seen <= 1'b0;
    end else begin
      high_speed_prev <= in_high_speed;
      high_speed_seen <= 1'b1;
    end
  end

  // Chopper and current controls by speed range.
  always @(posedge ref_clk) begin
    if (rst) begin
      high_speed <= 1'b0;
      load_adapt_en <= 1'b0;
      // Full current is the safe state until the speed range is known.
      normal_current_scale <= 1'b1;
      voltage_pwm_en <= 1'b0;
      chopper_type <= 1'b0;
      fast_decay_duration <= `FAST_DECAY_FORCED;
      fullstep_en <= 1'b0;
    end else begin
      high_speed <= in_high_speed;
      load_adapt_en <= load_adapt_active;
      normal_current_scale <= !load_adapt_active;
      voltage_pwm_en <= voltage_pwm_cfg_en && !in_high_speed;
      if (fast_chop_active) begin
        chopper_type <= `CHOPPER_TYPE_FORCED;
        fast_decay_duration <= `FAST_DECAY_FORCED;
      end else begin
        chopper_type <= chopper_type_cfg;
        fast_decay_duration <= fast_decay_cfg;
      end
      fullstep_en <= fast_fullstep_active;
    end
  end

  // Stall detection gating and method.
  always @(posedge ref_clk) begin
    if (rst) begin
      stall_detect_en <= 1'b0;
      dyn_step_stall_sel <= 1'b0;
    end else begin
      stall_detect_en <= stall_detect_cfg_en && !blanking && !crossing;
      dyn_step_stall_sel <= fast_fullstep_active;
    end
  end

  // Motion profile decode for the ramp generator.
  always @(posedge ref_clk) begin
    if (rst) begin
      positioning_mode <= 1'b1;
      velocity_mode <= 1'b0;
      velocity_target_negative <= 1'b0;
      main_accel_only <= 1'b0;
      hold_velocity <= 1'b0;
    end else begin
      positioning_mode <= 1'b0;
      velocity_mode <= 1'b0;
      velocity_target_negative <= 1'b0;
      main_accel_only <= 1'b0;
      hold_velocity <= 1'b0;
      case (motion_profile_select)
        `PROFILE_POSITIONING: begin
          positioning_mode <= 1'b1;
        end
        `PROFILE_VELOCITY_POS: begin
          velocity_mode <= 1'b1;
          main_accel_only <= 1'b1;
        end
        `PROFILE_VELOCITY_NEG: begin
          velocity_mode <= 1'b1;
          velocity_target_negative <= 1'b1;
          main_accel_only <= 1'b1;
        end
        `PROFILE_HOLD: begin
          // A stop event releases the hold so the ramp can brake.
          hold_velocity <= !stop_event;
        end
        default: begin
          positioning_mode <= 1'b1;
        end
      endcase
    end
  end

  // A position write in positioning mode changes the distance to go.
  always @(posedge ref_clk) begin
    if (rst) begin
      motion_start <= 1'b0;
    end else begin
      motion_start <= wr_position &&
                      (motion_profile_select == `PROFILE_POSITIONING);
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always @* begin
    next_rdata = `RST_RDATA;
    case (reg_addr)
      `ADDR_HIGH_SPEED_THRESHOLD: begin
        next_rdata = widen20(high_speed_step_time_threshold);
      end
      `ADDR_MOTION_PROFILE: begin
        next_rdata = widen_profile(motion_profile_select);
      end
      `ADDR_CURRENT_POSITION: begin
        next_rdata = current_position;
      end
      `ADDR_CURRENT_VELOCITY: begin
        next_rdata = widen_velocity(current_velocity);
      end
      default: begin
        next_rdata = `RST_RDATA;
      end
    endcase
  end

  // Read data is captured on the read strobe and held until the next one.
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= `RST_RDATA;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule // ramp_mode_and_speed_threshold
`default_nettype wire

// ===== verif/rmst_chk_sva.sv
// Assertion checker for the speed threshold and motion profile block.
`timescale 1ns/1ns
`default_nettype none
`include "ramp_mode_defs.vh"
module rmst_chk (
  input wire ref_clk,
  input wire rst,
  input wire [`REG_ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`REG_DATA_W-1:0] reg_rdata,
  input wire reg_rvalid,
  input wire fast_chopper_switch_en,
  input wire fast_fullstep_en,
  input wire electrical_period_tick,
  input wire high_speed,
  input wire load_adapt_en,
  input wire normal_current_scale,
  input wire voltage_pwm_en,
  input wire chopper_type,
  input wire [`FAST_DECAY_W-1:0] fast_decay_duration,
  input wire fullstep_en,
  input wire stall_detect_en,
  input wire dyn_step_stall_sel,
  input wire motion_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_cross; $changed(high_speed); endsequence
  sequence s_quiet; (!electrical_period_tick)[*2]; endsequence
  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_rhold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_cur; high_speed |-> normal_current_scale && !load_adapt_en; endproperty
  a_cur: assert property (p_cur) else $error("current reduction at high speed");
  property p_pwm; high_speed |-> !voltage_pwm_en; endproperty
  a_pwm: assert property (p_pwm) else $error("voltage pwm at high speed");
  property p_chop;
    high_speed && $past(fast_chopper_switch_en) |->
      chopper_type && fast_decay_duration == `FAST_DECAY_FORCED;
  endproperty
  a_chop: assert property (p_chop) else $error("chopper not forced");
  property p_fs; high_speed && $past(fast_fullstep_en) |-> fullstep_en && dyn_step_stall_sel;
  endproperty
  a_fs: assert property (p_fs) else $error("fullstep not selected");
  property p_blank; s_cross |-> !stall_detect_en; endproperty
  a_blank: assert property (p_blank) else $error("stall not blanked");
  property p_blank_hold; s_cross ##1 s_quiet |-> !stall_detect_en; endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("blanking too short");
  property p_start; !(reg_wr && reg_addr == `ADDR_CURRENT_POSITION) |=> !motion_start;
  endproperty
  a_start: assert property (p_start) else $error("motion start without write");
endmodule // rmst_chk
bind ramp_mode_and_speed_threshold rmst_chk u_chk (.ref_clk, .rst, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .reg_rvalid, .fast_chopper_switch_en, .fast_fullstep_en,
  .electrical_period_tick, .high_speed, .load_adapt_en, .normal_current_scale,
  .voltage_pwm_en, .chopper_type, .fast_decay_duration, .fullstep_en, .stall_detect_en,
  .dyn_step_stall_sel, .motion_start);
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the speed threshold and motion profile block.
`timescale 1ns/1ns
`default_nettype none
`include "ramp_mode_defs.vh"
module tb_top;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [31:0] reg_wdata = 32'h0, seed = 32'hb5d6;
  logic [19:0] intv = 20'h1, floor_v = 20'h0;
  logic ld_cfg = 0, vp_cfg = 0, fcs = 0, ffs = 0, ct_cfg = 0, sd_cfg = 0;
  logic tick = 0, rv_ok = 0, step = 0, stop = 0, start_seen = 0;
  logic [3:0] fd_cfg = 4'h0;
  logic [23:0] rv = 24'h0;
  wire [31:0] rdata;
  wire rvalid;
  wire [14:0] o;
  wire [3:0] fd;
  int num_errors = 0, checks = 0, cycles = 0, i, j;
  logic [6:0] am [5] = '{`ADDR_HIGH_SPEED_THRESHOLD, `ADDR_MOTION_PROFILE,
    `ADDR_CURRENT_POSITION, `ADDR_CURRENT_VELOCITY, 7'h7f};
  ramp_mode_and_speed_threshold dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .measured_step_interval(intv), .load_adapt_speed_floor(floor_v),
    .load_adapt_cfg_en(ld_cfg), .voltage_pwm_cfg_en(vp_cfg), .fast_chopper_switch_en(fcs),
    .fast_fullstep_en(ffs), .chopper_type_cfg(ct_cfg), .fast_decay_cfg(fd_cfg),
    .stall_detect_cfg_en(sd_cfg), .electrical_period_tick(tick), .ramp_velocity(rv),
    .ramp_velocity_valid(rv_ok), .step_pulse(step), .stop_event(stop), .high_speed(o[0]),
    .load_adapt_en(o[1]), .normal_current_scale(o[2]), .voltage_pwm_en(o[3]),
    .chopper_type(o[4]), .fast_decay_duration(fd), .fullstep_en(o[5]),
    .stall_detect_en(o[6]), .dyn_step_stall_sel(o[7]), .hold_velocity(o[8]),
    .main_accel_only(o[9]), .velocity_target_negative(o[10]), .velocity_mode(o[11]),
    .positioning_mode(o[12]), .motion_start(o[13]), .step_dir_down(o[14]));
  always #10 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction
  function automatic logic [31:0] fmask(input logic [6:0] a, input logic [31:0] d);
    case (a)
      `ADDR_HIGH_SPEED_THRESHOLD: fmask = d & 32'h000fffff;
      `ADDR_MOTION_PROFILE: fmask = d & 32'h00000003;
      `ADDR_CURRENT_POSITION: fmask = d;
      default: fmask = 32'h0;
    endcase
  endfunction
  function automatic logic [4:0] prof(input logic [1:0] p, input logic s);
    prof = {p == 2'h0, p[0] ^ p[1], p == 2'h2, p[0] ^ p[1], p == 2'h3 && !s};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    start_seen = o[13];
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", e, rdata);
    @(negedge ref_clk);
  endtask
  task automatic pulse_step;
    step = 1'b1;
    @(negedge ref_clk);
    step = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      tick = 1'b1;
      @(negedge ref_clk);
      tick = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    chk("reset_outs", 32'h1004, {17'h0, o});
    for (j = 0; j < 5; j++) rd(am[j], 32'h0);
    for (i = 0; i < 6; i++) begin
      for (j = 0; j < 5; j++) begin
        seed = (i == 0) ? 32'hffffffff : lfsr(seed);
        wr(am[j], seed);
        rd(am[j], fmask(am[j], seed));
      end
    end
    for (i = 0; i < 4; i++) begin
      wr(`ADDR_MOTION_PROFILE, i);
      chk("profile", {27'h0, prof(i[1:0], 1'b0)}, {27'h0, o[12:8]});
    end
    stop = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("hold_stop", {27'h0, prof(2'h3, 1'b1)}, {27'h0, o[12:8]});
    stop = 1'b0;
    wr(`ADDR_CURRENT_POSITION, 32'h5);
    chk("no_start", 32'h0, {31'h0, start_seen});
    wr(`ADDR_MOTION_PROFILE, 32'h0);
    wr(`ADDR_CURRENT_POSITION, 32'h10);
    chk("start", 32'h1, {31'h0, start_seen});
    @(negedge ref_clk);
    chk("start_end", 32'h0, {31'h0, o[13]});
    rv = 24'hfffffe;
    rv_ok = 1'b1;
    @(negedge ref_clk);
    rv_ok = 1'b0;
    wr(`ADDR_CURRENT_VELOCITY, 32'h1234);
    rd(`ADDR_CURRENT_VELOCITY, 32'h00fffffe);
    chk("dir_down", 32'h1, {31'h0, o[14]});
    pulse_step;
    rd(`ADDR_CURRENT_POSITION, 32'hf);
    rv = 24'h800000;
    rv_ok = 1'b1;
    @(negedge ref_clk);
    rv = {1'b0, seed[22:0]};
    rd(`ADDR_CURRENT_VELOCITY, 32'h00800001);
    rv_ok = 1'b0;
    pulse_step;
    rd(`ADDR_CURRENT_POSITION, 32'h10);
    {ld_cfg, vp_cfg, fcs, ffs, sd_cfg, fd_cfg, intv, floor_v} = {5'h1f, 4'h5, 20'd200, 20'd300};
    wr(`ADDR_HIGH_SPEED_THRESHOLD, 32'd100);
    ticks(4);
    chk("low_speed", 32'h26, {25'h0, o[7:3], o[1:0]});
    chk("decay_cfg", 32'h5, {28'h0, fd});
    intv = 20'd100;
    repeat (2) @(negedge ref_clk);
    chk("high_speed", 32'hb5, {24'h0, o[7:0]});
    chk("decay_forced", 32'h0, {28'h0, fd});
    repeat (2) @(negedge ref_clk);
    ticks(2);
    chk("blank_held", 32'h0, {31'h0, o[6]});
    ticks(1);
    @(negedge ref_clk);
    chk("blank_end", 32'h1, {31'h0, o[6]});
    intv = 20'd301;
    repeat (2) @(negedge ref_clk);
    chk("above_floor", 32'h0, {29'h0, o[6], o[1:0]});
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
